// ===== core/frs_defines.svh
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH
// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define FRS_CLK_MHZ       200
`define FRS_MS_CYC        (`FRS_CLK_MHZ * 1000)
`define FRS_S2MS(s)       ((s) * 1000)
// ----------------------------------------------------------------
// times in seconds, blink half period in ms
// ----------------------------------------------------------------
`define FRS_CC_LIMIT_S    20
`define FRS_HICCUP_DLY_S  3
`define FRS_OFF_MIN_S     2
`define FRS_OV_DLY_S      1
`define FRS_OV_WIN_S      60
`define FRS_ADDR_DLY_S    1
`define FRS_SYNC_OFF_S    20
`define FRS_BLINK_MS      500
`define FRS_OV_TRIES      3
`define FRS_FAN_PCT       20
// ----------------------------------------------------------------
// fault response config bits, 1 = latch off
// ----------------------------------------------------------------
`define FRS_CFG_OV        0
`define FRS_CFG_OT        1
`define FRS_CFG_OC        2
`define FRS_CFG_RST       3'h0
// ----------------------------------------------------------------
// status byte, alarm word and secondary status fields
// ----------------------------------------------------------------
`define FRS_ST_ON         0
`define FRS_ST_LATCH      1
`define FRS_ST_LIMIT      2
`define FRS_ST_INBAD      3
`define FRS_ST_CAUSE      4
`define FRS_ST_FAN        7
`define FRS_AL_FAN        9
`define FRS_AL_CAUSE      10
`define FRS_S2_RESTART    0
`define FRS_S2_ADDR_OK    1
// ----------------------------------------------------------------
// host register offsets
// ----------------------------------------------------------------
`define FRS_REG_CTRL      4'h0
`define FRS_REG_CMD       4'h4
`define FRS_REG_STAT      4'h8
`define FRS_REG_ALARM     4'hC
`endif

// ===== core/frs_pkg.sv
`include "frs_defines.svh"
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_OFF   = 3'h0,
    FRS_START = 3'h1,
    FRS_RUN   = 3'h3,
    FRS_WAIT  = 3'h2,
    FRS_LATCH = 3'h6
  } frs_state_e;

  typedef logic [15:0] frs_ms_t;

  // saturating millisecond counter step
  function automatic frs_ms_t frs_inc(frs_ms_t v, logic tick);
    frs_inc = (tick && v != 16'hFFFF) ? v + 16'h1 : v;
  endfunction
endpackage

// ===== core/frs_if.sv
interface frs_if;
  logic        en_pin;
  logic        op_on;
  logic        clr_faults;
  logic        rd_status;
  logic        cfg_wr;
  logic [2:0]  cfg_latch;
  logic        alert_n;
  logic        present;
  logic [7:0]  status;
  logic [15:0] alarm;
  logic [7:0]  status2;
  logic [6:0]  dev_addr;

  modport dev (
    input  en_pin, op_on, clr_faults, rd_status, cfg_wr, cfg_latch,
    output alert_n, present, status, alarm, status2, dev_addr
  );
  modport host (
    output en_pin, op_on, clr_faults, rd_status, cfg_wr, cfg_latch,
    input  alert_n, present, status, alarm, status2, dev_addr
  );
endinterface

// ===== core/frs_device.sv
`include "frs_defines.svh"
module frs_device
  import frs_pkg::*;
#(
  parameter int         MS_CYC  = `FRS_MS_CYC,
  parameter int         NFAN    = 2,
  parameter int         FANW    = 16,
  parameter logic [3:0] ADDR_HI = 4'h5
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  // converter sense
  input  wire logic                 in_limit_i,
  input  wire logic                 vout_hi_i,
  input  wire logic                 ov_evt_i,
  input  wire logic                 ot_evt_i,
  input  wire logic                 oc_evt_i,
  input  wire logic                 input_low_i,
  input  wire logic                 input_absent_i,
  input  wire logic [8:0]           info_alarm_i,
  input  wire logic [NFAN*FANW-1:0] fan_speed_i,
  // straps and backplane
  input  wire logic [2:0]           nv_latch_i,
  input  wire logic                 seated_i,
  input  wire logic [2:0]           slot_addr_i,
  // front panel and power stage
  output logic                      out_on_o,
  output logic                      out_led_o,
  output logic                      in_led_o,
  output logic                      fault_led_o,
  output logic                      fault_pin_o,
  // management link
  frs_if.dev                        link
);
  // ----------------------------------------------------------------
  // millisecond timebase and blink
  // ----------------------------------------------------------------
  logic [17:0] pre_q;
  logic [8:0]  blk_q;
  logic        blink_q;
  wire         tick = (pre_q == 18'(MS_CYC - 1));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_q   <= 18'h0;
      blk_q   <= 9'h0;
      blink_q <= 1'b0;
    end else begin
      pre_q <= tick ? 18'h0 : pre_q + 18'h1;
      if (tick) begin
        blk_q   <= (blk_q == 9'(`FRS_BLINK_MS - 1)) ? 9'h0 : blk_q + 9'h1;
        blink_q <= (blk_q == 9'(`FRS_BLINK_MS - 1)) ? ~blink_q : blink_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // fan spread
  // ----------------------------------------------------------------
  logic [FANW-1:0] fmx [NFAN];
  logic [FANW-1:0] fmn [NFAN];
  assign fmx[0] = fan_speed_i[FANW-1:0];
  assign fmn[0] = fan_speed_i[FANW-1:0];
  for (genvar g = 1; g < NFAN; g++) begin : g_fan
    wire [FANW-1:0] sp = fan_speed_i[g*FANW +: FANW];
    assign fmx[g] = (sp > fmx[g-1]) ? sp : fmx[g-1];
    assign fmn[g] = (sp < fmn[g-1]) ? sp : fmn[g-1];
  end
  wire [FANW+2:0] spread = {3'h0, fmx[NFAN-1] - fmn[NFAN-1]} * (FANW+3)'(100 / `FRS_FAN_PCT);
  wire            fan_warn = spread > {3'h0, fmx[NFAN-1]};

  // ----------------------------------------------------------------
  // output sequencer decode
  // ----------------------------------------------------------------
  frs_state_e st_q, st_d;
  frs_ms_t    st_ms_q, lim_ms_q, win_ms_q, up_ms_q;
  logic [2:0] cfg_q, cause_q;
  logic [1:0] ov_cnt_q;
  logic       init_q, wait_ov_q, lcnt_q, ext_q, had_fault_q;

  wire on_req   = link.en_pin & link.op_on & ~input_absent_i & seated_i;
  wire running  = (st_q == FRS_START) | (st_q == FRS_RUN);
  wire cc_exp   = (st_q == FRS_START) & in_limit_i &
                  (st_ms_q >= 16'(`FRS_S2MS(`FRS_CC_LIMIT_S)));
  wire hic_due  = (st_q == FRS_RUN) & (lim_ms_q >= 16'(`FRS_S2MS(`FRS_HICCUP_DLY_S)));
  // informational alarms feed only the alarm word and, through it, the attention, never this path
  wire oc_shut  = running & (oc_evt_i | cc_exp | hic_due);
  wire ov_shut  = running & ov_evt_i;
  wire ot_shut  = running & ot_evt_i;
  wire any_shut = oc_shut | ov_shut | ot_shut;
  wire ov_limit = (ov_cnt_q == 2'(`FRS_OV_TRIES - 1));
  wire to_latch = (ov_shut & (cfg_q[`FRS_CFG_OV] | ov_limit)) |
                  (ot_shut & cfg_q[`FRS_CFG_OT]) |
                  (oc_shut & cfg_q[`FRS_CFG_OC]);
  // a count latch is only released by cycling, never by config
  wire cfg_rel  = ~lcnt_q & ~|(cause_q & cfg_q);
  wire wait_done = st_ms_q >= (wait_ov_q ? 16'(`FRS_S2MS(`FRS_OV_DLY_S))
                                         : 16'(`FRS_S2MS(`FRS_OFF_MIN_S)));
  wire success  = (st_q == FRS_START) & (st_d == FRS_RUN) & had_fault_q;
  wire win_exp  = (ov_cnt_q != 2'h0) & (win_ms_q >= 16'(`FRS_S2MS(`FRS_OV_WIN_S)));

  always_comb begin
    st_d = st_q;
    case (st_q)
      FRS_OFF: begin
        if (on_req && st_ms_q >= 16'(`FRS_S2MS(`FRS_OFF_MIN_S))) st_d = FRS_START;
      end
      FRS_START, FRS_RUN: begin
        if (!on_req) st_d = FRS_OFF;
        else if (to_latch) st_d = FRS_LATCH;
        else if (any_shut) st_d = FRS_WAIT;
        else if (st_q == FRS_START && !in_limit_i) st_d = FRS_RUN;
      end
      FRS_WAIT: begin
        if (!on_req) st_d = FRS_OFF;
        else if (wait_done) st_d = FRS_START;
      end
      FRS_LATCH: begin
        if (!on_req) st_d = FRS_OFF;
        else if (cfg_rel) st_d = FRS_START;
      end
      default: st_d = FRS_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q     <= FRS_OFF;
      st_ms_q  <= 16'h0;
      lim_ms_q <= 16'h0;
      init_q   <= 1'b1;
      cfg_q    <= `FRS_CFG_RST;
    end else begin
      st_q     <= st_d;
      st_ms_q  <= (st_d != st_q) ? 16'h0 : frs_inc(st_ms_q, tick);
      lim_ms_q <= (st_q == FRS_RUN && in_limit_i && !vout_hi_i) ? frs_inc(lim_ms_q, tick) : 16'h0;
      init_q   <= 1'b0;
      if (init_q) cfg_q <= nv_latch_i;
      else if (link.cfg_wr) cfg_q <= link.cfg_latch;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cause_q     <= 3'h0;
      ext_q       <= 1'b0;
      had_fault_q <= 1'b0;
      wait_ov_q   <= 1'b0;
      lcnt_q      <= 1'b0;
    end else if (any_shut) begin
      cause_q     <= {oc_shut, ot_shut, ov_shut};
      ext_q       <= (cc_exp | hic_due) & ~oc_evt_i & ~ov_evt_i & ~ot_evt_i;
      had_fault_q <= 1'b1;
      wait_ov_q   <= ov_shut;
      lcnt_q      <= ov_shut & ov_limit & ~cfg_q[`FRS_CFG_OV];
    end else if (success) begin
      cause_q     <= 3'h0;
      had_fault_q <= 1'b0;
      lcnt_q      <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ov_cnt_q <= 2'h0;
      win_ms_q <= 16'h0;
    end else begin
      if (ov_shut) ov_cnt_q <= to_latch ? 2'h0 : ov_cnt_q + 2'h1;
      else if (win_exp) ov_cnt_q <= 2'h0;
      win_ms_q <= (ov_cnt_q == 2'h0 || win_exp) ? 16'h0 : frs_inc(win_ms_q, tick);
    end
  end

  // ----------------------------------------------------------------
  // notification registers
  // ----------------------------------------------------------------
  logic [7:0]  status_q, status2_q;
  logic [15:0] alarm_q;
  logic        frz_q, alert_q, pu_q, alert_n_q, present_q;
  logic [6:0]  addr_q;

  wire        latched = (st_q == FRS_LATCH);
  wire        out_on  = running;
  wire [7:0]  st_live = {fan_warn, cause_q, input_low_i | input_absent_i, in_limit_i, latched, out_on};
  wire [15:0] al_live = {3'h0, cause_q, fan_warn, info_alarm_i};
  wire [23:0] new_bits = {st_live, al_live} & ~{status_q, alarm_q};
  wire        stable   = (st_q == FRS_OFF) | (st_q == FRS_RUN) | latched;
  wire        chg      = stable & (frz_q ? |new_bits : {st_live, al_live} != {status_q, alarm_q});
  wire        alert_d  = chg | (alert_q & ~link.clr_faults);
  wire        pu_d     = pu_q & ~link.rd_status;
  wire        addr_ok  = up_ms_q >= 16'(`FRS_S2MS(`FRS_ADDR_DLY_S));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_q <= 8'h0;
      alarm_q  <= 16'h0;
      frz_q    <= 1'b0;
    end else if (success) begin
      // a frozen status keeps its bits until the clear, only alarms are wiped
      status_q <= frz_q ? status_q | st_live : st_live;
      alarm_q  <= 16'h0;
    end else if (link.clr_faults) begin
      status_q <= st_live;
      alarm_q  <= al_live;
      frz_q    <= chg;
    end else if (chg) begin
      status_q <= frz_q ? status_q | st_live : st_live;
      alarm_q  <= frz_q ? alarm_q | al_live : al_live;
      frz_q    <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alert_q   <= 1'b0;
      pu_q      <= 1'b1;
      alert_n_q <= 1'b1;
      status2_q <= 8'h0;
      up_ms_q   <= 16'h0;
      addr_q    <= 7'h0;
      present_q <= 1'b0;
    end else begin
      alert_q   <= alert_d;
      pu_q      <= pu_d;
      alert_n_q <= ~(alert_d | pu_d);
      status2_q[`FRS_S2_RESTART] <= success | (status2_q[`FRS_S2_RESTART] & ~link.clr_faults);
      status2_q[`FRS_S2_ADDR_OK] <= addr_ok;
      up_ms_q   <= seated_i ? frs_inc(up_ms_q, tick) : 16'h0;
      addr_q    <= {ADDR_HI, addr_ok ? slot_addr_i : 3'h0};
      present_q <= seated_i;
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_on_o    <= 1'b0;
      out_led_o   <= 1'b0;
      in_led_o    <= 1'b0;
      fault_led_o <= 1'b0;
      fault_pin_o <= 1'b0;
    end else begin
      out_on_o    <= out_on;
      out_led_o   <= latched ? 1'b0 : (out_on && in_limit_i && vout_hi_i) ? blink_q : out_on;
      in_led_o    <= input_absent_i ? 1'b0 : input_low_i ? blink_q : 1'b1;
      // overload latch-offs are external and stay dark
      fault_led_o <= (latched || st_q == FRS_WAIT) && |cause_q && !ext_q;
      fault_pin_o <= (latched || st_q == FRS_WAIT) && |cause_q && !ext_q;
    end
  end

  assign link.alert_n  = alert_n_q;
  assign link.present  = present_q;
  assign link.status   = status_q;
  assign link.alarm    = alarm_q;
  assign link.status2  = status2_q;
  assign link.dev_addr = addr_q;
endmodule // frs_device

// ===== core/frs_host.sv
`include "frs_defines.svh"
module frs_host
  import frs_pkg::*;
#(
  parameter int MS_CYC = `FRS_MS_CYC
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // management link
  frs_if.host              link
);
  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  logic [17:0] pre_q;
  wire         tick = (pre_q == 18'(MS_CYC - 1));
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) pre_q <= 18'h0;
    else pre_q <= tick ? 18'h0 : pre_q + 18'h1;
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [4:0] ctrl_q;
  logic       en_q, op_q, clr_q, rds_q, cfgw_q, sync_q, refused_q, pres_q;
  frs_ms_t    off_ms_q, sync_ms_q, grd_ms_q;

  wire wr_ctrl  = wr_i & (addr_i == `FRS_REG_CTRL);
  wire wr_cmd   = wr_i & (addr_i == `FRS_REG_CMD);
  wire rd_stat  = rd_i & (addr_i == `FRS_REG_STAT);
  // addressed commands are held back while a new unit configures its address
  wire guard    = grd_ms_q < 16'(`FRS_S2MS(`FRS_ADDR_DLY_S));
  wire want_clr = wr_cmd & wdata_i[0];
  wire want_cfg = wr_cmd & wdata_i[1];
  wire refuse   = guard & (want_clr | want_cfg | rd_stat);
  wire off_ok   = off_ms_q >= 16'(`FRS_S2MS(`FRS_OFF_MIN_S));
  wire sync_end = sync_ms_q >= 16'(`FRS_S2MS(`FRS_SYNC_OFF_S));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q    <= 5'h0;
      clr_q     <= 1'b0;
      rds_q     <= 1'b0;
      cfgw_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_i[4:0];
      clr_q     <= want_clr & ~guard;
      cfgw_q    <= want_cfg & ~guard;
      rds_q     <= rd_stat & ~guard;
      refused_q <= refuse | (refused_q & ~rd_stat);
    end
  end

  // ----------------------------------------------------------------
  // pins: off time before any turn-on, sync restart
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q      <= 1'b0;
      op_q      <= 1'b0;
      sync_q    <= 1'b0;
      off_ms_q  <= 16'h0;
      sync_ms_q <= 16'h0;
      pres_q    <= 1'b0;
      grd_ms_q  <= 16'h0;
    end else begin
      sync_q    <= (wr_cmd & wdata_i[2]) | (sync_q & ~sync_end);
      sync_ms_q <= sync_q ? frs_inc(sync_ms_q, tick) : 16'h0;
      en_q      <= ctrl_q[0] & ~sync_q & (en_q | off_ok);
      op_q      <= ctrl_q[1] & ~sync_q & (op_q | off_ok);
      off_ms_q  <= (en_q & op_q) ? 16'h0 : frs_inc(off_ms_q, tick);
      pres_q    <= link.present;
      grd_ms_q  <= (link.present & ~pres_q) ? 16'h0 : frs_inc(grd_ms_q, tick);
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0] stat_w  = {8'h0, link.status2, link.status, 3'h0, refused_q,
                         sync_q, ~guard, link.present, ~link.alert_n};
  wire [31:0] alarm_w = {9'h0, link.dev_addr, link.alarm};
  wire [31:0] rd_mux  = (addr_i == `FRS_REG_CTRL)  ? {27'h0, ctrl_q} :
                        (addr_i == `FRS_REG_STAT)  ? stat_w :
                        (addr_i == `FRS_REG_ALARM) ? alarm_w : 32'h0;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_o <= 32'h0;
    else if (rd_i) rdata_o <= rd_mux;
    else rdata_o <= 32'h0;
  end

  assign link.en_pin     = en_q;
  assign link.op_on      = op_q;
  assign link.clr_faults = clr_q;
  assign link.rd_status  = rds_q;
  assign link.cfg_wr     = cfgw_q;
  assign link.cfg_latch  = ctrl_q[4:2];
endmodule // frs_host

// ===== sim/frs_checker.sv
module frs_checker #(
  parameter int MS_CYC = 10
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // host driven link
  input  wire logic        en_pin,
  input  wire logic        op_on,
  input  wire logic        clr_faults,
  input  wire logic        rd_status,
  input  wire logic        cfg_wr,
  // device driven link
  input  wire logic        alert_n,
  input  wire logic        present,
  input  wire logic [7:0]  status,
  input  wire logic [15:0] alarm,
  input  wire logic [7:0]  status2,
  input  wire logic [6:0]  dev_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // off time of the enable pair, counted since reset or since the pair last went off
  // ----------------------------------------------------------------
  localparam int OFF_CYC = 2000 * MS_CYC;
  logic [31:0] off_cnt_q;
  wire         pins_on   = en_pin && op_on;
  wire  [31:0] off_cnt_d = pins_on ? 32'h0 : off_cnt_q + 32'h1;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) off_cnt_q <= 32'h0;
    else off_cnt_q <= off_cnt_d;
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_host_quiet;
    (!clr_faults && !cfg_wr && !rd_status) [*8];
  endsequence
  sequence s_addr_default;
    (dev_addr[2:0] == 3'h0) [*8];
  endsequence
  property p_host_quiet;
    $rose(present) |-> ##2 s_host_quiet;
  endproperty
  property p_addr_default;
    $rose(present) |=> ##1 s_addr_default;
  endproperty
  property p_off_hold;
    $rose(pins_on) |-> off_cnt_q >= OFF_CYC - 2;
  endproperty
  property p_restart_clr;
    clr_faults |=> !status2[0];
  endproperty
  property p_restart_alarm;
    $rose(status2[0]) |-> ##[0:1] alarm[12:10] == 3'h0;
  endproperty
  property p_alert_change;
    $changed(status) && !$past(clr_faults) |-> ##[0:1] !alert_n;
  endproperty
  property p_alert_hold;
    !alert_n && !clr_faults && !rd_status |=> !alert_n;
  endproperty
  property p_freeze;
    !alert_n && !$past(alert_n) && !$past(clr_faults) |-> ($past(status) & ~status) == 8'h00;
  endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("link command inside address settle time");
  a_addr_default: assert property (p_addr_default) else $error("address not default after insertion");
  a_off_hold: assert property (p_off_hold) else $error("enable pair rose too soon");
  a_restart_clr: assert property (p_restart_clr) else $error("restart bit kept after clear");
  a_restart_alarm: assert property (p_restart_alarm) else $error("alarm kept after restart");
  a_alert_change: assert property (p_alert_change) else $error("status change without attention");
  a_alert_hold: assert property (p_alert_hold) else $error("attention dropped without clear");
  a_freeze: assert property (p_freeze) else $error("frozen status lost a bit");
endmodule // frs_checker

// ===== sim/frs_tb.sv
`include "frs_defines.svh"
module frs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // stimulus and instances
  // ----------------------------------------------------------------
  localparam int MS  = 2;
  localparam int SEC = 1000 * MS;
  logic        core_clk_i = 1'b0;
  logic        resetn_i, in_limit_i, vout_hi_i, ov_evt_i, ot_evt_i, oc_evt_i;
  logic        input_low_i, input_absent_i, seated_i, wr_i, rd_i;
  logic [8:0]  info_alarm_i;
  logic [31:0] fan_speed_i, wdata_i, rdata_o, rd_v;
  logic [2:0]  nv_latch_i, slot_addr_i;
  logic [3:0]  addr_i;
  logic        out_on_o, out_led_o, in_led_o, fault_led_o, fault_pin_o;
  int          n_mismatch, n_compared, cyc_n;
  always #2.5 core_clk_i = ~core_clk_i;
  frs_if frs_if_i ();
  frs_device #(.MS_CYC(MS)) frs_device_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .in_limit_i(in_limit_i), .vout_hi_i(vout_hi_i), .ov_evt_i(ov_evt_i), .ot_evt_i(ot_evt_i),
    .oc_evt_i(oc_evt_i), .input_low_i(input_low_i), .input_absent_i(input_absent_i),
    .info_alarm_i(info_alarm_i), .fan_speed_i(fan_speed_i), .nv_latch_i(nv_latch_i), .seated_i(seated_i),
    .slot_addr_i(slot_addr_i), .out_on_o(out_on_o), .out_led_o(out_led_o), .in_led_o(in_led_o),
    .fault_led_o(fault_led_o), .fault_pin_o(fault_pin_o), .link(frs_if_i));
  frs_host #(.MS_CYC(MS)) frs_host_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(frs_if_i));
  frs_checker #(.MS_CYC(MS)) frs_checker_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .en_pin(frs_if_i.en_pin), .op_on(frs_if_i.op_on), .clr_faults(frs_if_i.clr_faults),
    .rd_status(frs_if_i.rd_status), .cfg_wr(frs_if_i.cfg_wr), .alert_n(frs_if_i.alert_n),
    .present(frs_if_i.present), .status(frs_if_i.status), .alarm(frs_if_i.alarm),
    .status2(frs_if_i.status2), .dev_addr(frs_if_i.dev_addr));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // waits end 1 ns past the edge so that its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask
  task automatic wait_on(input logic v, input int maxc);
    for (int i = 0; i < maxc && out_on_o !== v; i++) cyc(1);
    chk("out_on_o", out_on_o, v);
  endtask
  task automatic evt(input bit ov);
    @(posedge core_clk_i);
    if (ov) ov_evt_i <= 1'b1;
    else oc_evt_i <= 1'b1;
    @(posedge core_clk_i);
    ov_evt_i <= 1'b0;
    oc_evt_i <= 1'b0;
  endtask
  task automatic toggles(input bit in_side, input int n);
    int   t;
    logic p;
    t = 0;
    repeat (n) begin
      p = in_side ? in_led_o : out_led_o;
      cyc(1);
      if ((in_side ? in_led_o : out_led_o) !== p) t++;
    end
    chk("led_toggles", t >= 2, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    cyc(3);
    chk("alert_n", frs_if_i.alert_n, 1'b0);
    chk("dev_addr", frs_if_i.dev_addr, {4'h5, 3'h0});
    wr(`FRS_REG_CMD, 32'h1);
    cyc(SEC + 200);
    chk("dev_addr", frs_if_i.dev_addr, {4'h5, 3'h3});
    rd(`FRS_REG_STAT);
    chk("stat", rd_v[4:0], 5'h17);
    cyc(3);
    chk("alert_n", frs_if_i.alert_n, 1'b1);
    rd(4'h2);
    chk("unmapped", rd_v, 32'h0);
  endtask
  task automatic t_turn_on();
    wr(`FRS_REG_CTRL, 32'h3);
    wait_on(1'b1, 3 * SEC);
    cyc(3);
    chk("out_led_o", out_led_o, 1'b1);
    chk("alert_n", frs_if_i.alert_n, 1'b0);
    wr(`FRS_REG_CMD, 32'h1);
    cyc(3);
    chk("alert_n", frs_if_i.alert_n, 1'b1);
  endtask
  task automatic t_ov_restart();
    evt(1'b1);
    wait_on(1'b0, 4);
    chk("fault_led_o", fault_led_o, 1'b1);
    wait_on(1'b1, SEC + 50);
    cyc(4);
    chk("restart_ok", frs_if_i.status2[0], 1'b1);
    chk("alarm", frs_if_i.alarm[12:10], 3'h0);
    @(posedge core_clk_i);
    fan_speed_i <= {16'h02BC, 16'h03E8};
    cyc(3);
    chk("fan_warn", frs_if_i.status[7], 1'b1);
    wr(`FRS_REG_CMD, 32'h1);
    cyc(3);
    chk("restart_ok", frs_if_i.status2[0], 1'b0);
  endtask
  task automatic t_oc_latch();
    wr(`FRS_REG_CTRL, 32'h13);
    wr(`FRS_REG_CMD, 32'h2);
    cyc(2);
    evt(1'b0);
    wait_on(1'b0, 4);
    cyc(2 * SEC + 200);
    chk("latched", frs_if_i.status[1], 1'b1);
    chk("out_led_o", out_led_o, 1'b0);
    chk("fault_pin_o", fault_pin_o, 1'b1);
    wr(`FRS_REG_CTRL, 32'h3);
    wr(`FRS_REG_CMD, 32'h2);
    wait_on(1'b1, 50);
    wr(`FRS_REG_CMD, 32'h1);
  endtask
  task automatic t_limit();
    @(posedge core_clk_i);
    in_limit_i <= 1'b1;
    vout_hi_i  <= 1'b1;
    toggles(1'b0, SEC + 200);
    @(posedge core_clk_i);
    vout_hi_i <= 1'b0;
    cyc(3 * SEC - 100);
    chk("out_on_o", out_on_o, 1'b1);
    wait_on(1'b0, 300);
    chk("fault_led_o", fault_led_o, 1'b0);
    @(posedge core_clk_i);
    in_limit_i <= 1'b0;
    cyc(2 * SEC - 100);
    chk("out_on_o", out_on_o, 1'b0);
    wait_on(1'b1, 400);
  endtask
  task automatic t_sync();
    wr(`FRS_REG_CMD, 32'h4);
    cyc(4);
    chk("en_pin", frs_if_i.en_pin, 1'b0);
    rd(`FRS_REG_STAT);
    chk("sync_busy", rd_v[3], 1'b1);
    cyc(20 * SEC - 100);
    chk("out_on_o", out_on_o, 1'b0);
    wait_on(1'b1, 300);
  endtask
  task automatic t_input();
    @(posedge core_clk_i);
    input_low_i  <= 1'b1;
    info_alarm_i <= 9'h1FF;
    toggles(1'b1, SEC + 200);
    chk("out_on_o", out_on_o, 1'b1);
    chk("info_alarm", frs_if_i.alarm[8:0], 9'h1FF);
    @(posedge core_clk_i);
    input_low_i    <= 1'b0;
    input_absent_i <= 1'b1;
    cyc(4);
    chk("in_led_o", in_led_o, 1'b0);
  endtask
  // ceiling well above the roughly 65000 cycles the scenarios need
  always @(posedge core_clk_i) begin
    cyc_n++;
    if (cyc_n == 80000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    {resetn_i, in_limit_i, vout_hi_i, ov_evt_i, ot_evt_i, oc_evt_i} = 6'h00;
    {input_low_i, input_absent_i, wr_i, rd_i} = 4'h0;
    seated_i     = 1'b1;
    info_alarm_i = 9'h000;
    fan_speed_i  = {16'h03E8, 16'h03E8};
    nv_latch_i   = 3'h0;
    slot_addr_i  = 3'h3;
    addr_i       = 4'h0;
    wdata_i      = 32'h0;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_powerup();
    t_turn_on();
    t_ov_restart();
    t_oc_latch();
    t_limit();
    t_sync();
    t_input();
    stop_test();
  end
endmodule // frs_tb
